// ==== hdl/eis_ext_irq.v ====
// External interrupt sensitivity, top-level interrupt and vector priority registers
module eis_ext_irq
(
   input wire mclk, // Clock, 20 MHz
   input wire nrst, // Async reset, active low
   input wire [7:0] avs_address, // Register byte address
   input wire avs_read, // Read request
   input wire avs_write, // Write request
   input wire [7:0] avs_writedata, // Write data
   output reg [7:0] avs_readdata, // Read data
   output wire avs_waitrequest, // Wait request
   input wire [3:0] pin_irq_group, // Combined pin level per group
   input wire top_level_pin, // Dedicated top-level pin
   input wire cpu_prio_hi, // CPU priority bit 1
   input wire cpu_prio_lo, // CPU priority bit 0
   input wire [3:0] group_ack, // Vector serviced, one per group
   input wire top_ack, // Top-level request serviced
   input wire can_wake_sc, // CAN bus wake-up status change
   input wire serial_rx_pin_irq, // External interrupt on serial receive pin
   input wire halt_active, // Device is in halt
   output wire [3:0] group_pending, // Pending flag per group
   output reg top_level_irq, // Top-level request pending
   output wire [1:0] top_irq_ctl, // Edge select and enable
   output wire [7:0] group_sense, // All sensitivity fields
   output wire [27:0] vector_prio, // Fourteen two-bit priorities
   output wire halt_wake, // Wake request out of halt
   output wire [2:0] power_mode // Selected power mode
);
`include "eis_regs.vh"

   reg [7:0] pin_irq_sensitivity_r;
   reg [7:0] top_irq_control_r;
   wire [7:0] vector_priority_0_r;
   wire [7:0] vector_priority_1_r;
   wire [7:0] vector_priority_2_r;
   wire [7:0] vector_priority_3_r;
   wire [3:0] group_pend_r;
   reg top_prev_r;
   reg [2:0] mode_r;
   reg ack_r;

   wire rd_req = avs_read & ~avs_write;
   wire wr_req = avs_write & ~avs_read;
   // Writes land at the edge that sees waitrequest low
   wire wr_take = wr_req & ack_r;
   wire cpu_lvl3 = ({cpu_prio_hi, cpu_prio_lo} == `EIS_LVL3);
   wire wr_sense = wr_take & (avs_address == `EIS_OFF_SENSE) & cpu_lvl3;
   wire wr_top = wr_take & (avs_address == `EIS_OFF_TOP);
   wire wr_prio0 = wr_take & (avs_address == `EIS_OFF_PRIO0);
   wire wr_prio1 = wr_take & (avs_address == `EIS_OFF_PRIO1);
   wire wr_prio2 = wr_take & (avs_address == `EIS_OFF_PRIO2);
   wire wr_prio3 = wr_take & (avs_address == `EIS_OFF_PRIO3);
   wire top_en = top_irq_control_r[`EIS_TOP_EN_BIT];
   wire top_edge = top_irq_control_r[`EIS_TOP_EDGE_BIT];
   wire top_evt = top_edge ? (top_level_pin & ~top_prev_r)
      : (~top_level_pin & top_prev_r);

   // One wait state: answer one cycle after the request appears
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         ack_r <= 1'b0;
      else
         ack_r <= (avs_read | avs_write) & ~ack_r;
   end

   // Priority registers, one cell per byte
   eis_prio_byte
   #(
      .RO_MASK(8'h00)
   )
   prio0_i
   (
      .mclk(mclk),
      .nrst(nrst),
      .wr_en(wr_prio0),
      .wdata(avs_writedata),
      .prio_q(vector_priority_0_r)
   );

   eis_prio_byte
   #(
      .RO_MASK(8'h00)
   )
   prio1_i
   (
      .mclk(mclk),
      .nrst(nrst),
      .wr_en(wr_prio1),
      .wdata(avs_writedata),
      .prio_q(vector_priority_1_r)
   );

   eis_prio_byte
   #(
      .RO_MASK(8'h00)
   )
   prio2_i
   (
      .mclk(mclk),
      .nrst(nrst),
      .wr_en(wr_prio2),
      .wdata(avs_writedata),
      .prio_q(vector_priority_2_r)
   );

   // Upper nibble of the last byte always reads one
   eis_prio_byte
   #(
      .RO_MASK(`EIS_PRIO3_RO)
   )
   prio3_i
   (
      .mclk(mclk),
      .nrst(nrst),
      .wr_en(wr_prio3),
      .wdata(avs_writedata),
      .prio_q(vector_priority_3_r)
   );

   // Sensitivity and top-level control registers
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_irq_sensitivity_r <= `EIS_SENSE_RST;
         top_irq_control_r <= `EIS_TOP_RST;
         mode_r <= `EIS_MODE_RUN;
      end
      else
      begin
         if (wr_sense)
            pin_irq_sensitivity_r <= avs_writedata;
         if (wr_top)
         begin
            top_irq_control_r[`EIS_TOP_EN_BIT] <= avs_writedata[`EIS_TOP_EN_BIT];
            if (!top_en)
               top_irq_control_r[`EIS_TOP_EDGE_BIT] <= avs_writedata[`EIS_TOP_EDGE_BIT];
         end
         if (wr_take & (avs_address == `EIS_OFF_MODE) & (avs_writedata[2:0] <= 3'h5))
            mode_r <= avs_writedata[2:0];
      end
   end

   // Group event capture cells; set wins over clear
   eis_sense_cell
   #(
      .PREV_RST(1'b1)
   )
   sense0_i
   (
      .mclk(mclk),
      .nrst(nrst),
      .pin(pin_irq_group[0]),
      .sense_sel(pin_irq_sensitivity_r[1:0]),
      .sense_wr(wr_sense),
      .sense_new(avs_writedata[1:0]),
      .ack(group_ack[0]),
      .pending(group_pend_r[0])
   );

   eis_sense_cell
   #(
      .PREV_RST(1'b1)
   )
   sense1_i
   (
      .mclk(mclk),
      .nrst(nrst),
      .pin(pin_irq_group[1]),
      .sense_sel(pin_irq_sensitivity_r[3:2]),
      .sense_wr(wr_sense),
      .sense_new(avs_writedata[3:2]),
      .ack(group_ack[1]),
      .pending(group_pend_r[1])
   );

   eis_sense_cell
   #(
      .PREV_RST(1'b1)
   )
   sense2_i
   (
      .mclk(mclk),
      .nrst(nrst),
      .pin(pin_irq_group[2]),
      .sense_sel(pin_irq_sensitivity_r[5:4]),
      .sense_wr(wr_sense),
      .sense_new(avs_writedata[5:4]),
      .ack(group_ack[2]),
      .pending(group_pend_r[2])
   );

   eis_sense_cell
   #(
      .PREV_RST(1'b1)
   )
   sense3_i
   (
      .mclk(mclk),
      .nrst(nrst),
      .pin(pin_irq_group[3]),
      .sense_sel(pin_irq_sensitivity_r[7:6]),
      .sense_wr(wr_sense),
      .sense_new(avs_writedata[7:6]),
      .ack(group_ack[3]),
      .pending(group_pend_r[3])
   );

   // Top-level pin sample and request flag
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         top_prev_r <= 1'b1;
         top_level_irq <= 1'b0;
      end
      else
      begin
         top_prev_r <= top_level_pin;
         // Enable falling may leave one stray request standing
         if (top_en & top_evt)
            top_level_irq <= 1'b1;
         else if (top_ack)
            top_level_irq <= 1'b0;
         else if (wr_top & top_en & ~avs_writedata[`EIS_TOP_EN_BIT] & top_evt)
            top_level_irq <= 1'b1;
      end
   end

   // Read mux
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         avs_readdata <= 8'h00;
      else if (rd_req & ~ack_r)
      begin
         case (avs_address)
            `EIS_OFF_PRIO0: avs_readdata <= vector_priority_0_r;
            `EIS_OFF_PRIO1: avs_readdata <= vector_priority_1_r;
            `EIS_OFF_PRIO2: avs_readdata <= vector_priority_2_r;
            `EIS_OFF_PRIO3: avs_readdata <= vector_priority_3_r;
            `EIS_OFF_SENSE: avs_readdata <= pin_irq_sensitivity_r;
            `EIS_OFF_TOP: avs_readdata <= {6'h00, top_irq_control_r[1:0]};
            `EIS_OFF_STATUS: avs_readdata <= {3'h0, top_level_irq, group_pending};
            `EIS_OFF_MODE: avs_readdata <= {5'h00, mode_r};
            default: avs_readdata <= 8'h00;
         endcase
      end
   end

   assign group_pending = group_pend_r;
   assign top_irq_ctl = top_irq_control_r[1:0];
   assign group_sense = pin_irq_sensitivity_r;
   assign vector_prio = {vector_priority_3_r[3:0], vector_priority_2_r,
      vector_priority_1_r, vector_priority_0_r};
   assign power_mode = mode_r;
   // Halt exit sources
   assign halt_wake = halt_active & (top_level_irq | (|group_pend_r) | can_wake_sc
      | serial_rx_pin_irq);
endmodule // eis_ext_irq

// One priority register byte with level-0 write filter
module eis_prio_byte
#(
   parameter [7:0] RO_MASK = 8'h00 // Bits held at one, writes ignored
)
(
   input wire mclk, // Clock
   input wire nrst, // Async reset, active low
   input wire wr_en, // Write taken for this byte
   input wire [7:0] wdata, // Write data
   output reg [7:0] prio_q // Stored priorities
);
   reg [7:0] merged;
   integer k;

   // Level-0 pairs keep the old value
   always @*
   begin
      merged = prio_q;
      for (k = 0; k < 4; k = k + 1)
      begin
         if (wdata[2*k +: 2] != `EIS_LVL0)
            merged[2*k +: 2] = wdata[2*k +: 2];
      end
      merged = merged | RO_MASK;
   end

   // Register, all ones out of reset
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         prio_q <= `EIS_PRIO_RST;
      else if (wr_en)
         prio_q <= merged;
   end
endmodule // eis_prio_byte

// Edge and level capture with pending flag for one pin group
module eis_sense_cell
#(
   parameter [0:0] PREV_RST = 1'b1 // Prior sample after reset, pin idle level
)
(
   input wire mclk, // Clock
   input wire nrst, // Async reset, active low
   input wire pin, // Group pin level
   input wire [1:0] sense_sel, // Current sensitivity code
   input wire sense_wr, // Sensitivity write taken
   input wire [1:0] sense_new, // Code being written
   input wire ack, // Vector serviced
   output wire pending // Pending flag
);
   reg pin_prev_r;
   reg pend_r;
   reg hit;
   reg pend_nxt;

   // Event decode against the prior sample
   always @*
   begin
      case (sense_sel)
         `EIS_SEN_FALL_LOW: hit = ~pin;
         `EIS_SEN_RISE: hit = pin & ~pin_prev_r;
         `EIS_SEN_FALL: hit = ~pin & pin_prev_r;
         `EIS_SEN_BOTH: hit = pin ^ pin_prev_r;
         default: hit = 1'b0;
      endcase
   end

   // Clears first, so a same-cycle event wins
   always @*
   begin
      pend_nxt = pend_r;
      if (ack)
         pend_nxt = 1'b0;
      if (sense_wr && (sense_new != sense_sel))
         pend_nxt = 1'b0;
      if (hit)
         pend_nxt = 1'b1;
   end

   // Sample and flag registers
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_prev_r <= PREV_RST;
         pend_r <= 1'b0;
      end
      else
      begin
         pin_prev_r <= pin;
         pend_r <= pend_nxt;
      end
   end

   assign pending = pend_r;
endmodule // eis_sense_cell

// ==== hdl/eis_regs.vh ====
// Register offsets, field positions, reset values and codes of the external interrupt block
`ifndef EIS_REGS_VH
`define EIS_REGS_VH
`define EIS_OFF_PRIO0 8'h25
`define EIS_OFF_PRIO1 8'h26
`define EIS_OFF_PRIO2 8'h27
`define EIS_OFF_PRIO3 8'h28
`define EIS_OFF_SENSE 8'h29
`define EIS_OFF_TOP 8'h2A
`define EIS_OFF_STATUS 8'h2B
`define EIS_OFF_MODE 8'h2C
`define EIS_PRIO_RST 8'hFF
`define EIS_SENSE_RST 8'h00
`define EIS_TOP_RST 8'h00
`define EIS_PRIO3_RO 8'hF0
`define EIS_TOP_EN_BIT 0
`define EIS_TOP_EDGE_BIT 1
`define EIS_LVL0 2'h2
`define EIS_LVL3 2'h3
`define EIS_SEN_FALL_LOW 2'h0
`define EIS_SEN_RISE 2'h1
`define EIS_SEN_FALL 2'h2
`define EIS_SEN_BOTH 2'h3
`define EIS_MODE_RUN 3'h0
`define EIS_MODE_SLOW 3'h1
`define EIS_MODE_WAIT 3'h2
`define EIS_MODE_AHALT 3'h3
`define EIS_MODE_AWU 3'h4
`define EIS_MODE_HALT 3'h5
`endif

// ==== sim/eis_cpu_model.sv ====
// CPU interrupt level model driving the two priority bits
module eis_cpu_model
(
   input wire mclk, // Clock
   input wire nrst, // Reset, active low
   input wire di_req, // High: interrupts off
   output logic cpu_prio_hi, // Level bit 1
   output logic cpu_prio_lo // Level bit 0
);
   timeunit 1ns;
   timeprecision 1ns;
   // Level 3 out of reset; disable loads 11, enable loads 10
   always @(posedge mclk or negedge nrst)
   begin
      cpu_prio_hi <= 1'b1;
      cpu_prio_lo <= !nrst || di_req;
   end
endmodule // eis_cpu_model

// ==== sim/eis_props.sv ====
// Checker of locks and event capture of the external interrupt block
module eis_props
(
   input wire mclk, // Clock
   input wire nrst, // Reset
   input wire [7:0] avs_address, // Address
   input wire avs_read, // Read
   input wire avs_write, // Write
   input wire [7:0] avs_writedata, // Data
   input wire avs_waitrequest, // Wait
   input wire [3:0] pin_irq_group, // Pins
   input wire top_level_pin, // Top pin
   input wire cpu_prio_hi, // Level 1
   input wire cpu_prio_lo, // Level 0
   input wire [3:0] group_pending, // Pending
   input wire top_level_irq, // Top req
   input wire [1:0] top_irq_ctl, // Edge, enable
   input wire [7:0] group_sense, // Sense
   input wire [27:0] vector_prio // Priorities
);
   timeunit 1ns;
   timeprecision 1ns;
   // Write taken at the edge that sees waitrequest low
   wire take = avs_write && !avs_waitrequest;
   wire lvl3 = cpu_prio_hi && cpu_prio_lo;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("Wait state too long");
   a_sense_lock: assert property (take && avs_address == 8'h29 && !lvl3
      |=> $stable(group_sense)) else $error("Sense write not blocked");
   a_sense_take: assert property (take && avs_address == 8'h29 && lvl3
      |=> group_sense == $past(avs_writedata)) else $error("Sense write lost");
   a_edge_lock: assert property (take && avs_address == 8'h2A && top_irq_ctl[0]
      |=> top_irq_ctl[1] == $past(top_irq_ctl[1])) else $error("Edge bit changed");
   a_enable_free: assert property (take && avs_address == 8'h2A
      |=> top_irq_ctl[0] == $past(avs_writedata[0])) else $error("Enable not written");
   a_lvl0_keep: assert property (take && avs_address == 8'h25 && avs_writedata[5:4] == 2'h2
      |=> $stable(vector_prio[5:4])) else $error("Level 0 pair stored");
   a_rise_hit: assert property (group_sense[1:0] == 2'h1 && $rose(pin_irq_group[0])
      |=> group_pending[0]) else $error("Rising edge missed");
   a_low_hit: assert property (group_sense[1:0] == 2'h0 && !pin_irq_group[0]
      |=> group_pending[0]) else $error("Low level missed");
   a_top_rise: assert property (top_irq_ctl == 2'h3 && $rose(top_level_pin)
      |=> top_level_irq) else $error("Top rising edge missed");
endmodule // eis_props
bind eis_ext_irq eis_props eis_props_i (.*);

// ==== sim/tb.sv ====
// Testbench of the external interrupt block
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic avs_read = 1'b0, avs_write = 1'b0, di_req = 1'b1, top_level_pin = 1'b1, top_ack = 1'b0;
   logic [7:0] avs_address = 8'h00, avs_writedata = 8'h00, avs_readdata, q;
   logic [3:0] pin_irq_group = 4'hF, group_ack = 4'h0, group_pending;
   logic can_wake_sc = 1'b0, serial_rx_pin_irq = 1'b0, halt_active = 1'b0;
   wire avs_waitrequest, top_level_irq, cpu_prio_hi, cpu_prio_lo, halt_wake;
   int fails = 0, cmp_count = 0, cyc = 0;
   // Rows: sense code, pin before, pin after, expected pending
   logic [4:0] rows [8] = '{5'h05, 5'h01, 5'h0B, 5'h0C, 5'h15, 5'h12, 5'h1B, 5'h1D};
   eis_ext_irq eis_ext_irq_i (.mclk, .nrst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .pin_irq_group, .top_level_pin,
      .cpu_prio_hi, .cpu_prio_lo, .group_ack, .top_ack, .can_wake_sc,
      .serial_rx_pin_irq, .halt_active, .group_pending, .top_level_irq,
      .top_irq_ctl(), .group_sense(), .vector_prio(), .halt_wake, .power_mode());
   eis_cpu_model eis_cpu_model_i (.mclk, .nrst, .di_req, .cpu_prio_hi, .cpu_prio_lo);
   always #25 mclk = ~mclk;
   // Hang guard
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         complete_run;
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bus cycle: hold until wait low at a rising edge, then release
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(q, exp);
   endtask
   task automatic complete_run;
      $display("fails=%0d cmp_count=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 6; i++) rd_chk(8'(8'h25 + i), i < 4 ? 8'hFF : 8'h00);
      rd_chk(8'h2C, 8'h00);
      foreach (rows[i])
      begin
         bus(1'b1, 8'h29, {4{rows[i][4:3]}});
         pin_irq_group <= {4{rows[i][2]}};
         repeat (2) @(posedge mclk);
         group_ack <= 4'hF;
         repeat (2) @(posedge mclk);
         group_ack <= 4'h0;
         pin_irq_group <= {4{rows[i][1]}};
         repeat (3) @(posedge mclk);
         chk({4'h0, group_pending}, {8{rows[i][0]}} & 8'h0F);
      end
      di_req <= 1'b0;
      @(posedge mclk);
      bus(1'b1, 8'h29, 8'h5A);
      rd_chk(8'h29, 8'hFF);
      di_req <= 1'b1;
      @(posedge mclk);
      bus(1'b1, 8'h29, 8'hAA);
      rd_chk(8'h29, 8'hAA);
      pin_irq_group <= 4'hF;
      @(posedge mclk);
      pin_irq_group <= 4'h0;
      repeat (2) @(posedge mclk);
      bus(1'b1, 8'h29, 8'hA9);
      chk({4'h0, group_pending}, 8'h0E);
      bus(1'b1, 8'h2A, 8'h01);
      top_level_pin <= 1'b0;
      repeat (2) @(posedge mclk);
      chk({7'h00, top_level_irq}, 8'h01);
      bus(1'b1, 8'h2A, 8'h03);
      rd_chk(8'h2A, 8'h01);
      bus(1'b1, 8'h2A, 8'h00);
      bus(1'b1, 8'h2A, 8'h03);
      rd_chk(8'h2A, 8'h03);
      top_ack <= 1'b1;
      @(posedge mclk);
      top_ack <= 1'b0;
      @(posedge mclk);
      chk({7'h00, top_level_irq}, 8'h00);
      top_level_pin <= 1'b1;
      repeat (2) @(posedge mclk);
      chk({7'h00, top_level_irq}, 8'h01);
      bus(1'b1, 8'h25, 8'hCF);
      bus(1'b1, 8'h25, 8'h64);
      rd_chk(8'h25, 8'h44);
      bus(1'b1, 8'h28, 8'h00);
      rd_chk(8'h28, 8'hF0);
      rd_chk(8'h30, 8'h00);
      rd_chk(8'h2B, 8'h1E);
      bus(1'b1, 8'h2C, 8'h05);
      bus(1'b1, 8'h2C, 8'h07);
      rd_chk(8'h2C, 8'h05);
      group_ack <= 4'hF;
      top_ack <= 1'b1;
      @(posedge mclk);
      group_ack <= 4'h0;
      top_ack <= 1'b0;
      halt_active <= 1'b1;
      @(posedge mclk);
      chk({7'h00, halt_wake}, 8'h00);
      can_wake_sc <= 1'b1;
      @(posedge mclk);
      chk({7'h00, halt_wake}, 8'h01);
      can_wake_sc <= 1'b0;
      serial_rx_pin_irq <= 1'b1;
      @(posedge mclk);
      chk({7'h00, halt_wake}, 8'h01);
      serial_rx_pin_irq <= 1'b0;
      bus(1'b1, 8'h2A, 8'h00);
      complete_run;
   end
endmodule // tb
